// ===== port_alternate_functions.sv
// Purpose: Four 8-bit I/O ports with their alternate functions.
// Assumes: Pin inputs are synchronous to I_CLK_SYS; board pull-ups.
// Notes: Pin outputs and core-facing levels are one cycle behind.
// Behaviour
// R1: Latch one drives pin high, zero low; port zero only releases the pin for a one.
// R2: Each port: latch, driver, input buffer.
// R3: Port zero: low address with strobe, then data.
// R4: Port two outputs the upper address byte.
// R5: Board ties access select low for bus.
// R6: Non-loop: port three bit zero shows direction.
// R7: Loop or diagnostic: bit zero receives data.
// R8: Non-loop: bit one is bidirectional serial data.
// R9: Loop: bit one is transmit output only.
// R10: Latch zero on bit one selects diagnostic.
// R11: Bit two feeds interrupt zero, gate zero.
// R12: Bit three feeds interrupt one, gate one.
// R13: Bit four is timer zero count input.
// R14: Bit five: timer one count, serial clock.
// R15: Bit six is low-active external write strobe.
// R16: Bit seven is low-active external read strobe.
// R17: Port one bit six is request-to-send.
// R18: Port one bit seven is clear-to-send input.
// R19: Latches at 80h..B0h, bit addressable.
// R20: Port reads return the sampled pin level.
//
// Design decision made here: the APB register port.
module port_alternate_functions
    import port_alt_pkg::*;
(
    input wire logic I_CLK_SYS,
    input wire logic I_RST,
    input wire logic I_PSEL,
    input wire logic I_PENABLE,
    input wire logic I_PWRITE,
    input wire logic [APB_ADDR_W-1:0] I_PADDR,
    input wire logic [31:0] I_PWDATA,
    output logic [31:0] O_PRDATA,
    output logic O_PREADY,
    output logic O_PSLVERR,
    input wire port_vec_t I_PORT_IN,
    output port_vec_t O_PORT_OUT,
    output port_vec_t O_PORT_OE_N,
    input wire logic I_EXTERNAL_ACCESS_SELECT_N,
    input wire xmem_t I_XMEM,
    output byte_t O_XMEM_RDATA,
    input wire serial_t I_SERIAL,
    input wire timer_sel_t I_TIMER_SEL,
    output alt_in_t O_ALT_IN
);

    port_vec_t latch;
    port_vec_t want;
    port_vec_t next_out;
    port_vec_t next_oe_n;
    alt_in_t next_alt_in;
    logic xmem_on;
    logic loop_mode;
    logic diag_mode;
    logic apb_setup;
    logic apb_write;
    logic rd_hit;
    logic [31:0] rd_value;
    logic bit_ok;
    logic [BIT_PORT_W-1:0] bit_port;
    logic [BIT_IDX_W-1:0] bit_idx;

    // External bus only when the board strap allows it
    assign xmem_on = ~I_EXTERNAL_ACCESS_SELECT_N & I_XMEM.active; // R5
    assign loop_mode = I_SERIAL.loop_mode_select;
    assign diag_mode = ~latch[PORT_THREE][P3_DATA_BIT]; // R10

    assign apb_setup = I_PSEL & ~I_PENABLE;
    assign apb_write = I_PSEL & I_PENABLE & I_PWRITE;
    // Read data is prepared in the setup cycle, so no wait states
    assign O_PREADY = I_PSEL & I_PENABLE;

    assign bit_ok = (I_PWDATA[BIT_BASE_LSB +: 2] == BIT_BASE) &&
        !I_PWDATA[BIT_HOLE_POS];
    assign bit_port = I_PWDATA[BIT_PORT_LSB +: BIT_PORT_W];
    assign bit_idx = I_PWDATA[BIT_IDX_LSB +: BIT_IDX_W];

    always_comb
    begin
        rd_hit = 1'b1;
        rd_value = '0;
        case (I_PADDR)
            ADDR_PORT0: rd_value[PORT_W-1:0] = I_PORT_IN[PORT_ZERO]; // R20
            ADDR_PORT1: rd_value[PORT_W-1:0] = I_PORT_IN[PORT_ONE]; // R20
            ADDR_PORT2: rd_value[PORT_W-1:0] = I_PORT_IN[PORT_TWO]; // R20
            ADDR_PORT3: rd_value[PORT_W-1:0] = I_PORT_IN[PORT_THREE]; // R20
            ADDR_BIT_OP: rd_value = '0;
            ADDR_STATUS:
            begin
                rd_value[STAT_DIAG_POS] = diag_mode;
                rd_value[STAT_LOOP_POS] = loop_mode;
                rd_value[STAT_XMEM_POS] = xmem_on;
            end
            ADDR_LATCH_VIEW: rd_value = latch;
            default: rd_hit = 1'b0;
        endcase
    end

    always_ff @(posedge I_CLK_SYS)
    begin
        if (I_RST)
        begin
            O_PRDATA <= '0;
            O_PSLVERR <= 1'b0;
        end
        else if (apb_setup)
        begin
            O_PRDATA <= I_PWRITE ? '0 : rd_value;
            O_PSLVERR <= ~rd_hit;
        end
    end

    always_ff @(posedge I_CLK_SYS)
    begin
        if (I_RST)
        begin
            latch <= {NUM_PORTS{LATCH_RESET}};
        end
        else if (apb_write)
        begin
            case (I_PADDR)
                ADDR_PORT0: latch[PORT_ZERO] <= I_PWDATA[PORT_W-1:0]; // R2
                ADDR_PORT1: latch[PORT_ONE] <= I_PWDATA[PORT_W-1:0]; // R2
                ADDR_PORT2: latch[PORT_TWO] <= I_PWDATA[PORT_W-1:0]; // R2
                ADDR_PORT3: latch[PORT_THREE] <= I_PWDATA[PORT_W-1:0]; // R2
                ADDR_BIT_OP:
                begin
                    if (bit_ok)
                    begin
                        latch[bit_port][bit_idx] <= I_PWDATA[BIT_VALUE_POS]; // R19
                    end
                end
                default: ;
            endcase
        end
    end

    // Port one and three alternate outputs, except the loop-mode transmit bit, pull the pin low through the latch, so software
    // must leave the latch bit at one to hand the pin over.
    always_comb
    begin
        want = latch;
        want[PORT_ONE][P1_RTS_BIT] = latch[PORT_ONE][P1_RTS_BIT] &
            I_SERIAL.rts_n; // R17
        want[PORT_THREE][P3_WR_BIT] = latch[PORT_THREE][P3_WR_BIT] &
            ~(xmem_on & I_XMEM.wr_strobe); // R15
        want[PORT_THREE][P3_RD_BIT] = latch[PORT_THREE][P3_RD_BIT] &
            ~(xmem_on & I_XMEM.rd_strobe); // R16
        want[PORT_THREE][P3_DATA_BIT] = latch[PORT_THREE][P3_DATA_BIT] &
            I_SERIAL.txd; // R8
        if (!loop_mode && !diag_mode)
        begin
            want[PORT_THREE][P3_DIR_BIT] = latch[PORT_THREE][P3_DIR_BIT] &
                I_SERIAL.dir; // R6
        end
        if (loop_mode)
        begin
            want[PORT_THREE][P3_DATA_BIT] = I_SERIAL.txd; // R9
        end
        next_out = want;
        // Zero drives low; a rising one drives high for one cycle, then the
        // pull-up holds it so the pin can serve as an input. Port zero is
        // open drain and never drives high from its latch.
        for (int p = 0; p < NUM_PORTS; p++)
        begin
            if (p == PORT_ZERO)
            begin
                next_oe_n[p] = want[p]; // R1
            end
            else
            begin
                next_oe_n[p] = want[p] & O_PORT_OUT[p]; // R1
            end
        end
        if (loop_mode || diag_mode)
        begin
            next_oe_n[PORT_THREE][P3_DIR_BIT] = 1'b1; // R7
        end
        if (loop_mode)
        begin
            next_oe_n[PORT_THREE][P3_DATA_BIT] = 1'b0; // R9
        end
        if (xmem_on)
        begin
            next_out[PORT_ZERO] = I_XMEM.ale ?
                I_XMEM.addr[PORT_W-1:0] : I_XMEM.wdata; // R3
            next_oe_n[PORT_ZERO] =
                {PORT_W{~(I_XMEM.ale | I_XMEM.drive_data)}}; // R3
            next_out[PORT_TWO] = I_XMEM.addr[XMEM_ADDR_W-1:PORT_W]; // R4
            next_oe_n[PORT_TWO] = '0; // R4
        end
    end

    always_ff @(posedge I_CLK_SYS)
    begin
        if (I_RST)
        begin
            O_PORT_OUT <= {NUM_PORTS{LATCH_RESET}};
            O_PORT_OE_N <= {NUM_PORTS{LATCH_RESET}};
        end
        else
        begin
            O_PORT_OUT <= next_out;
            O_PORT_OE_N <= next_oe_n;
        end
    end

    always_comb
    begin
        next_alt_in.ext_irq_zero_n = I_PORT_IN[PORT_THREE][P3_IRQ0_BIT]; // R11
        next_alt_in.gate0 = I_PORT_IN[PORT_THREE][P3_IRQ0_BIT]; // R11
        next_alt_in.ext_irq_one_n = I_PORT_IN[PORT_THREE][P3_IRQ1_BIT]; // R12
        next_alt_in.gate1 = I_PORT_IN[PORT_THREE][P3_IRQ1_BIT]; // R12
        // Unselected count inputs idle high so no falling edge is seen
        next_alt_in.timer0_count = I_TIMER_SEL.count0_sel ?
            I_PORT_IN[PORT_THREE][P3_T0_BIT] : 1'b1; // R13
        next_alt_in.timer1_count = I_TIMER_SEL.count1_sel ?
            I_PORT_IN[PORT_THREE][P3_T1_BIT] : 1'b1; // R14
        next_alt_in.serial_ext_clk = I_SERIAL.ext_clk_sel &
            I_PORT_IN[PORT_THREE][P3_T1_BIT]; // R14
        next_alt_in.serial_rx = (loop_mode || diag_mode) ?
            I_PORT_IN[PORT_THREE][P3_DIR_BIT] :
            I_PORT_IN[PORT_THREE][P3_DATA_BIT]; // R7 R8
        next_alt_in.clear_to_send_n = I_PORT_IN[PORT_ONE][P1_CTS_BIT]; // R18
        next_alt_in.diag_mode = diag_mode; // R10
    end

    always_ff @(posedge I_CLK_SYS)
    begin
        if (I_RST)
        begin
            O_ALT_IN <= ALT_IN_RESET;
            O_XMEM_RDATA <= '0;
        end
        else
        begin
            O_ALT_IN <= next_alt_in;
            O_XMEM_RDATA <= I_PORT_IN[PORT_ZERO]; // R3
        end
    end

    default clocking cb @(posedge I_CLK_SYS);
    endclocking
    default disable iff (I_RST);

    sequence s_wr_port1_bit0(logic v);
        apb_write && I_PADDR == ADDR_PORT1 && I_PWDATA[0] == v;
    endsequence

    sequence s_pin10_driven(logic v);
        O_PORT_OUT[PORT_ONE][0] == v && !O_PORT_OE_N[PORT_ONE][0];
    endsequence

    property p_latch_low;
        s_wr_port1_bit0(1'b0) |=> ##1 s_pin10_driven(1'b0);
    endproperty
    a_latch_low: assert property (p_latch_low) // R1
        else $error("port one bit zero not driven low after write");

    property p_latch_high;
        s_wr_port1_bit0(1'b1) ##0 !latch[PORT_ONE][0]
            |=> ##1 s_pin10_driven(1'b1);
    endproperty
    a_latch_high: assert property (p_latch_high) // R1
        else $error("port one bit zero not driven high after write");

    sequence s_addr_phase;
        xmem_on && I_XMEM.ale;
    endsequence

    property p_addr_low;
        s_addr_phase |=> O_PORT_OUT[PORT_ZERO] == $past(I_XMEM.addr[7:0])
            && O_PORT_OE_N[PORT_ZERO] == '0;
    endproperty
    a_addr_low: assert property (p_addr_low) // R3
        else $error("port zero missing low address byte");

    property p_data_out;
        xmem_on && !I_XMEM.ale && I_XMEM.drive_data
            |=> O_PORT_OUT[PORT_ZERO] == $past(I_XMEM.wdata);
    endproperty
    a_data_out: assert property (p_data_out) // R3
        else $error("port zero missing write data");

    property p_addr_high;
        xmem_on |=> O_PORT_OUT[PORT_TWO] == $past(I_XMEM.addr[15:8])
            && O_PORT_OE_N[PORT_TWO] == '0;
    endproperty
    a_addr_high: assert property (p_addr_high) // R4
        else $error("port two missing high address byte");

    property p_dir_out;
        !loop_mode && !diag_mode && !I_SERIAL.dir
            |=> !O_PORT_OUT[PORT_THREE][P3_DIR_BIT]
            && !O_PORT_OE_N[PORT_THREE][P3_DIR_BIT];
    endproperty
    a_dir_out: assert property (p_dir_out) // R6
        else $error("direction pin not driven low");

    property p_rx_in;
        (loop_mode || diag_mode) |=> O_PORT_OE_N[PORT_THREE][P3_DIR_BIT]
            && O_ALT_IN.serial_rx == $past(I_PORT_IN[PORT_THREE][0]);
    endproperty
    a_rx_in: assert property (p_rx_in) // R7
        else $error("receive pin not used as input");

    property p_data_pin;
        !loop_mode && !diag_mode |=> O_ALT_IN.serial_rx ==
            $past(I_PORT_IN[PORT_THREE][P3_DATA_BIT]);
    endproperty
    a_data_pin: assert property (p_data_pin) // R8
        else $error("serial data pin not received");

    property p_txd;
        loop_mode |=> !O_PORT_OE_N[PORT_THREE][P3_DATA_BIT]
            && O_PORT_OUT[PORT_THREE][P3_DATA_BIT] == $past(I_SERIAL.txd);
    endproperty
    a_txd: assert property (p_txd) // R9
        else $error("transmit pin not following txd");

    property p_diag;
        apb_write && I_PADDR == ADDR_PORT3 && !I_PWDATA[P3_DATA_BIT]
            |=> ##1 O_ALT_IN.diag_mode;
    endproperty
    a_diag: assert property (p_diag) // R10
        else $error("diagnostic mode not entered");

    property p_irq;
        !$past(I_RST) |-> O_ALT_IN.gate0 == $past(I_PORT_IN[PORT_THREE][2])
            && O_ALT_IN.ext_irq_one_n == $past(I_PORT_IN[PORT_THREE][3]);
    endproperty
    a_irq: assert property (p_irq) // R11 R12
        else $error("interrupt inputs not following pins");

    property p_count0;
        I_TIMER_SEL.count0_sel
            |=> O_ALT_IN.timer0_count == $past(I_PORT_IN[PORT_THREE][4]);
    endproperty
    a_count0: assert property (p_count0) // R13
        else $error("timer zero count input wrong");

    property p_count1;
        I_TIMER_SEL.count1_sel
            |=> O_ALT_IN.timer1_count == $past(I_PORT_IN[PORT_THREE][5]);
    endproperty
    a_count1: assert property (p_count1) // R14
        else $error("timer one count input wrong");

    property p_wr_strobe;
        xmem_on && I_XMEM.wr_strobe |=> !O_PORT_OUT[PORT_THREE][P3_WR_BIT]
            && !O_PORT_OE_N[PORT_THREE][P3_WR_BIT];
    endproperty
    a_wr_strobe: assert property (p_wr_strobe) // R15
        else $error("write strobe not asserted");

    property p_rd_strobe;
        xmem_on && I_XMEM.rd_strobe |=> !O_PORT_OUT[PORT_THREE][P3_RD_BIT]
            && !O_PORT_OE_N[PORT_THREE][P3_RD_BIT];
    endproperty
    a_rd_strobe: assert property (p_rd_strobe) // R16
        else $error("read strobe not asserted");

    property p_rts;
        !I_SERIAL.rts_n |=> !O_PORT_OUT[PORT_ONE][P1_RTS_BIT];
    endproperty
    a_rts: assert property (p_rts) // R17
        else $error("request to send not asserted");

    property p_bit_op;
        apb_write && I_PADDR == ADDR_BIT_OP && bit_ok
            |=> latch[$past(bit_port)][$past(bit_idx)] ==
            $past(I_PWDATA[BIT_VALUE_POS]);
    endproperty
    a_bit_op: assert property (p_bit_op) // R19
        else $error("bit write did not reach latch");

    property p_read_pin;
        apb_setup && !I_PWRITE && I_PADDR == ADDR_PORT1
            |=> O_PRDATA[PORT_W-1:0] == $past(I_PORT_IN[PORT_ONE]);
    endproperty
    a_read_pin: assert property (p_read_pin) // R20
        else $error("port read did not return pin level");

endmodule : port_alternate_functions

// ===== port_alt_pkg.sv
// Purpose: Shared constants and carrier types for the port block.
// Assumes: APB byte addresses, one 32-bit word per register.
// Notes: Port pins are split into level in, level out and output enable.
package port_alt_pkg;

    localparam int NUM_PORTS = 4;
    localparam int PORT_W = 8;
    localparam int APB_ADDR_W = 8;
    localparam int XMEM_ADDR_W = 16;

    localparam int PORT_ZERO = 0;
    localparam int PORT_ONE = 1;
    localparam int PORT_TWO = 2;
    localparam int PORT_THREE = 3;

    localparam logic [APB_ADDR_W-1:0] ADDR_PORT0 = 8'h80;
    localparam logic [APB_ADDR_W-1:0] ADDR_PORT1 = 8'h90;
    localparam logic [APB_ADDR_W-1:0] ADDR_PORT2 = 8'hA0;
    localparam logic [APB_ADDR_W-1:0] ADDR_PORT3 = 8'hB0;
    localparam logic [APB_ADDR_W-1:0] ADDR_BIT_OP = 8'hC0;
    localparam logic [APB_ADDR_W-1:0] ADDR_STATUS = 8'hC4;
    localparam logic [APB_ADDR_W-1:0] ADDR_LATCH_VIEW = 8'hC8;

    localparam logic [PORT_W-1:0] LATCH_RESET = 8'hFF;

    // Bit operation word: bit address in [7:0], value in [8]
    localparam int BIT_IDX_LSB = 0;
    localparam int BIT_IDX_W = 3;
    localparam int BIT_HOLE_POS = 3;
    localparam int BIT_PORT_LSB = 4;
    localparam int BIT_PORT_W = 2;
    localparam int BIT_BASE_LSB = 6;
    localparam logic [1:0] BIT_BASE = 2'h2;
    localparam int BIT_VALUE_POS = 8;

    localparam int STAT_DIAG_POS = 0;
    localparam int STAT_LOOP_POS = 1;
    localparam int STAT_XMEM_POS = 2;

    localparam int P1_RTS_BIT = 6;
    localparam int P1_CTS_BIT = 7;
    localparam int P3_DIR_BIT = 0;
    localparam int P3_DATA_BIT = 1;
    localparam int P3_IRQ0_BIT = 2;
    localparam int P3_IRQ1_BIT = 3;
    localparam int P3_T0_BIT = 4;
    localparam int P3_T1_BIT = 5;
    localparam int P3_WR_BIT = 6;
    localparam int P3_RD_BIT = 7;

    typedef logic [PORT_W-1:0] byte_t;
    typedef byte_t [NUM_PORTS-1:0] port_vec_t;

    typedef struct packed {
        logic active;
        logic ale;
        logic drive_data;
        logic wr_strobe;
        logic rd_strobe;
        logic [XMEM_ADDR_W-1:0] addr;
        byte_t wdata;
    } xmem_t;

    typedef struct packed {
        logic loop_mode_select;
        logic dir;
        logic txd;
        logic rts_n;
        logic ext_clk_sel;
    } serial_t;

    typedef struct packed {
        logic count0_sel;
        logic count1_sel;
    } timer_sel_t;

    typedef struct packed {
        logic ext_irq_zero_n;
        logic ext_irq_one_n;
        logic gate0;
        logic gate1;
        logic timer0_count;
        logic timer1_count;
        logic serial_ext_clk;
        logic serial_rx;
        logic clear_to_send_n;
        logic diag_mode;
    } alt_in_t;

    localparam alt_in_t ALT_IN_RESET = '{
        ext_irq_zero_n: 1'b1, ext_irq_one_n: 1'b1, gate0: 1'b1,
        gate1: 1'b1, timer0_count: 1'b1, timer1_count: 1'b1,
        serial_ext_clk: 1'b0, serial_rx: 1'b1, clear_to_send_n: 1'b1,
        diag_mode: 1'b0};

endpackage : port_alt_pkg

// ===== port_board_model.sv
// Purpose: Board around the ports: pull-ups, external drivers, memory.
// Assumes: Every pin has a pull-up and all drivers resolve as wired-AND.
// Notes: Memory answers a read with the high address byte XOR A5h.
module port_board_model
    import port_alt_pkg::*;
(
    input wire port_vec_t i_out,
    input wire port_vec_t i_oe_n,
    input wire port_vec_t i_ext_en,
    input wire port_vec_t i_ext_val,
    output port_vec_t o_pins
);
    logic rd_low;
    byte_t mem_data;

    // Strobe taken from the device drive, not the pin, to avoid a loop
    assign rd_low = !i_oe_n[PORT_THREE][P3_RD_BIT]
        && !i_out[PORT_THREE][P3_RD_BIT];
    assign mem_data = rd_low ? (i_out[PORT_TWO] ^ 8'hA5) : 8'hFF;

    always_comb
    begin
        for (int p = 0; p < NUM_PORTS; p++)
        begin
            // Released bits float to the pull-up level
            o_pins[p] = (i_out[p] | i_oe_n[p])
                & (i_ext_val[p] | ~i_ext_en[p]);
        end
        o_pins[PORT_ZERO] = o_pins[PORT_ZERO] & mem_data;
    end
endmodule : port_board_model

// ===== port_alternate_functions_tb_top.sv
// Purpose: Self-checking bench for the port block.
// Assumes: Board model resolves pins and feeds them back as inputs.
// Notes: Driver queues expectations; a monitor pops and compares them.
module port_alternate_functions_tb_top
    import port_alt_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    typedef struct {
        int sel;
        string name;
        logic [31:0] exp;
        logic [31:0] mask;
        logic err;
    } note_t;
    logic clk, rst, psel, penable, pwrite, pready, pslverr, sel_n, snap_on;
    logic [APB_ADDR_W-1:0] paddr;
    logic [31:0] pwdata, prdata, view;
    port_vec_t pins, p_out, p_oe_n, ext_en, ext_val;
    xmem_t xm;
    byte_t xm_rd;
    serial_t ser;
    timer_sel_t tsel;
    alt_in_t alt, exp_alt, alt_mask;
    note_t notes[$];
    int n_mismatch = 0;
    int total_checks = 0;

    port_alternate_functions port_alternate_functions_inst (
        .I_CLK_SYS(clk), .I_RST(rst), .I_PSEL(psel), .I_PENABLE(penable),
        .I_PWRITE(pwrite), .I_PADDR(paddr), .I_PWDATA(pwdata),
        .O_PRDATA(prdata), .O_PREADY(pready), .O_PSLVERR(pslverr),
        .I_PORT_IN(pins), .O_PORT_OUT(p_out), .O_PORT_OE_N(p_oe_n),
        .I_EXTERNAL_ACCESS_SELECT_N(sel_n), .I_XMEM(xm),
        .O_XMEM_RDATA(xm_rd), .I_SERIAL(ser), .I_TIMER_SEL(tsel),
        .O_ALT_IN(alt));
    port_board_model port_board_model_inst (.i_out(p_out),
        .i_oe_n(p_oe_n), .i_ext_en(ext_en), .i_ext_val(ext_val),
        .o_pins(pins));

    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    task automatic stop_test();
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : stop_test

    task automatic chk(input string name, input logic [31:0] seen,
        input logic [31:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("BAD %s expected %h seen %h", name, exp, seen);
        end
    endtask : chk

    task automatic snap(input int sel, input string name,
        input logic [31:0] exp, input logic [31:0] mask);
        notes.push_back('{sel, name, exp, mask, 1'b0});
        @(posedge clk) snap_on <= 1'b1;
        @(posedge clk) snap_on <= 1'b0;
    endtask : snap

    task automatic apb(input logic wr, input logic [7:0] addr,
        input logic [31:0] wd, input logic [31:0] exp, input logic err);
        int k;
        k = 0;
        notes.push_back('{4, "apb", exp, wr ? 32'h0 : 32'hFFFF_FFFF, err});
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= addr;
        pwdata <= wd;
        @(posedge clk);
        penable <= 1'b1;
        do
        begin
            @(posedge clk);
            k++;
        end while (pready !== 1'b1 && k < 16);
        psel <= 1'b0;
        penable <= 1'b0;
        if (k >= 16)
        begin
            n_mismatch++;
            stop_test();
        end
    endtask : apb

    always @(posedge clk)
    begin
        note_t n;
        logic [31:0] seen;
        if ((psel && penable && pready === 1'b1) || snap_on)
        begin
            if (notes.size() == 0)
                chk("note queue", 32'h1, 32'h0);
            else
            begin
                n = notes.pop_front();
                case (n.sel)
                    0: seen = pins;
                    1: seen = 32'(alt);
                    2: seen = 32'(xm_rd);
                    default: seen = prdata;
                endcase
                chk(n.name, seen & n.mask, n.exp & n.mask);
                if (n.sel == 4)
                    chk("pslverr", 32'(pslverr), 32'(n.err));
            end
        end
    end

    initial
    begin
        repeat (50000) @(posedge clk);
        n_mismatch++;
        stop_test();
    end

    initial
    begin
        logic [31:0] r;
        logic [15:0] a;
        byte_t v;
        logic [7:0] ba;
        rst = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = '0;
        pwdata = '0;
        sel_n = 1'b1;
        xm = '0;
        ser = '{1'b0, 1'b1, 1'b1, 1'b1, 1'b0};
        tsel = '0;
        ext_en = '0;
        ext_val = '0;
        snap_on = 1'b0;
        void'($urandom(61));
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        apb(0, ADDR_LATCH_VIEW, 0, {4{LATCH_RESET}}, 0);
        view = {4{LATCH_RESET}};
        for (int p = 0; p < NUM_PORTS; p++)
        begin
            v = 8'($urandom);
            // Keep diagnostic mode off while the latches are exercised
            if (p == PORT_THREE)
                v[P3_DATA_BIT] = 1'b1;
            ba = ADDR_PORT0 + 8'(p * 16);
            apb(1, ba, 32'(v), 0, 0);
            repeat (4) @(posedge clk);
            apb(0, ba, 0, 32'(v), 0);
            view[p*8 +: 8] = v;
        end
        apb(0, ADDR_LATCH_VIEW, 0, view, 0);
        snap(0, "pins", view, '1);
        for (int p = 0; p < NUM_PORTS; p++)
        begin
            r = $urandom;
            if (p == PORT_THREE && r[2:0] == 3'(P3_DATA_BIT))
                r[8] = 1'b1;
            r[7:0] = 8'h80 + 8'(p * 16) + 8'(r[2:0]);
            apb(1, ADDR_BIT_OP, {23'h0, r[8:0]}, 0, 0);
            view[p*8 + int'(r[2:0])] = r[8];
        end
        apb(1, ADDR_BIT_OP, 32'h188, 0, 0);
        apb(1, 8'h84, 32'h0, 0, 1);
        apb(0, 8'h84, 0, 0, 1);
        apb(0, ADDR_LATCH_VIEW, 0, view, 0);
        apb(1, ADDR_BIT_OP, 32'h192, 0, 0);
        view[10] = 1'b1;
        ext_en <= 32'h0000_0400;
        repeat (4) @(posedge clk);
        apb(0, ADDR_PORT1, 0, 32'(view[15:8] & 8'hFB), 0);
        apb(0, ADDR_LATCH_VIEW, 0, view, 0);
        ext_en <= '0;
        for (int p = 0; p < NUM_PORTS; p++)
            apb(1, ADDR_PORT0 + 8'(p * 16), 32'hFF, 0, 0);
        for (int i = 0; i < 6; i++)
        begin
            r = $urandom;
            ext_en <= 32'h3C00_8000;
            ext_val <= {2'b11, r[3:0], 10'h3FF, r[4], 15'h7FFF};
            tsel <= '{count0_sel: r[5], count1_sel: r[6]};
            ser.ext_clk_sel <= r[7];
            ser.rts_n <= r[8];
            repeat (4) @(posedge clk);
            exp_alt = ALT_IN_RESET;
            exp_alt.ext_irq_zero_n = r[0];
            exp_alt.gate0 = r[0];
            exp_alt.ext_irq_one_n = r[1];
            exp_alt.gate1 = r[1];
            exp_alt.timer0_count = r[5] ? r[2] : 1'b1;
            exp_alt.timer1_count = r[6] ? r[3] : 1'b1;
            exp_alt.serial_ext_clk = r[7] & r[3];
            exp_alt.clear_to_send_n = r[4];
            snap(1, "alt inputs", 32'(exp_alt), '1);
            snap(0, "rts pin", 32'(r[8]) << 14, 32'h4000);
        end
        ser.rts_n <= 1'b1;
        alt_mask = '0;
        alt_mask.serial_rx = 1'b1;
        for (int i = 0; i < 8; i++)
        begin
            r = $urandom;
            // A transmit-only pin is not driven from outside
            if (i[2])
                r[1] = 1'b1;
            ser.loop_mode_select <= i[2];
            ser.dir <= i[1];
            ser.txd <= i[0];
            ext_en <= 32'h0300_0000;
            ext_val <= {6'h3F, r[1:0], 24'hFFFFFF};
            repeat (4) @(posedge clk);
            v[0] = i[2] ? r[0] : (i[1] & r[0]);
            v[1] = i[0] & r[1];
            exp_alt = '0;
            exp_alt.serial_rx = i[2] ? v[0] : v[1];
            snap(0, "serial pins", {6'h0, v[1:0], 24'h0}, 32'h0300_0000);
            snap(1, "serial rx", 32'(exp_alt), 32'(alt_mask));
            apb(0, ADDR_STATUS, 0, 32'(i[2]) << STAT_LOOP_POS, 0);
        end
        ser <= '{1'b0, 1'b1, 1'b1, 1'b1, 1'b0};
        r = $urandom;
        ext_val <= {6'h3F, 1'b1, r[0], 24'hFFFFFF};
        // Whole-byte write clears the data latch bit to enter diagnostic
        apb(1, ADDR_PORT3, 32'hFD, 0, 0);
        repeat (4) @(posedge clk);
        apb(0, ADDR_STATUS, 0, 32'h1, 0);
        exp_alt = '0;
        exp_alt.serial_rx = r[0];
        exp_alt.diag_mode = 1'b1;
        alt_mask.diag_mode = 1'b1;
        snap(1, "diag rx", 32'(exp_alt), 32'(alt_mask));
        apb(1, ADDR_BIT_OP, 32'h1B1, 0, 0);
        ext_en <= '0;
        // Top address bit kept low so a released port two is told apart
        a = 16'($urandom) & 16'h7FFF;
        r = $urandom;
        sel_n <= 1'b0;
        xm <= '{1'b1, 1'b1, 1'b0, 1'b0, 1'b0, a, r[7:0]};
        repeat (4) @(posedge clk);
        snap(0, "address", {8'h0, a[15:8], 8'h0, a[7:0]}, 32'h00FF_00FF);
        apb(0, ADDR_STATUS, 0, 32'h4, 0);
        xm.ale <= 1'b0;
        xm.drive_data <= 1'b1;
        xm.wr_strobe <= 1'b1;
        repeat (4) @(posedge clk);
        snap(0, "write", {8'h80, a[15:8], 8'h0, r[7:0]}, 32'hC0FF_00FF);
        xm.drive_data <= 1'b0;
        xm.wr_strobe <= 1'b0;
        xm.rd_strobe <= 1'b1;
        repeat (4) @(posedge clk);
        snap(2, "read data", 32'(a[15:8] ^ 8'hA5), 32'hFF);
        snap(0, "read strobe", 32'h4000_0000, 32'hC000_0000);
        sel_n <= 1'b1;
        repeat (4) @(posedge clk);
        snap(0, "bus off", 32'h00FF_0000, 32'h00FF_0000);
        xm <= '0;
        // Disturb a latch so the reset check below has something to undo
        apb(1, ADDR_PORT0, 32'h0, 0, 0);
        @(posedge clk) rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        apb(0, ADDR_LATCH_VIEW, 0, {4{LATCH_RESET}}, 0);
        stop_test();
    end
endmodule : port_alternate_functions_tb_top
